// *** hw/pcp_map.vh ***
// field layout and timing constants of the counter programming port
`ifndef PCP_MAP_VH
`define PCP_MAP_VH
`define PCP_PRI_W        20
`define PCP_ENH_W        8
`define PCP_PRE_EN_BIT   19
`define PCP_M_HI         18
`define PCP_M_LO         10
`define PCP_R_HI         9
`define PCP_R_LO         4
`define PCP_A_HI         3
`define PCP_A_LO         0
`define PCP_ENH_MON_OFF  0
`define PCP_CLK_NS       100
`define PCP_DEFAULT_CNT  4'h0
`define PCP_RST_MAIN     9'h000
`define PCP_RST_REF      6'h00
`define PCP_RST_ENH      8'h00
`endif

// *** hw/pcp_port.v ***
// programming front end: primary, secondary and enhancement words and counter source mux
//
// Contract
// - serial words arrive most significant bit first
// - shift clock loads primary or enhancement word
// - serial mode: source select picks primary/secondary
// - parallel mode: source select picks primary/secondary
// - prescaler enable low; high bypasses prescaler
// - enhancement strobe latches all data bits
// - upper main strobe latches reference/main top bits
// - lower main strobe latches prescaler, main low
// - swallow strobe latches reference low and all swallow bits
// - serial select chooses serial or parallel mode
// - direct select ignores serial and parallel ports
// - transfer strobe copies primary into secondary
// - main divider monitor, gated by enhancement bit
// - direct mode takes counters from static pins
// - serial load strobe rise copies primary word
// - enhancement bits act only while enable low
`include "pcp_map.vh"
module pcp_port (
   clk,
   reset,
   serial_data_in,
   shift_clk,
   enh_strobe,
   serial_load_strobe,
   upper_main_strobe,
   lower_main_strobe,
   swallow_strobe,
   transfer_strobe,
   par_data,
   serial_select,
   direct_select,
   serial_source_select,
   parallel_source_select,
   extras_active_n,
   direct_main,
   direct_swallow,
   direct_ref,
   direct_pre_en_n,
   main_divider_in,
   cnt_main,
   cnt_ref,
   cnt_swallow,
   prescaler_bypass,
   enh_effective,
   main_divider_monitor
);
   input  wire        clk;
   input  wire        reset;
   input  wire        serial_data_in;
   input  wire        shift_clk;
   input  wire        enh_strobe;
   input  wire        serial_load_strobe;
   input  wire        upper_main_strobe;
   input  wire        lower_main_strobe;
   input  wire        swallow_strobe;
   input  wire        transfer_strobe;
   input  wire [7:0]  par_data;
   input  wire        serial_select;
   input  wire        direct_select;
   input  wire        serial_source_select;
   input  wire        parallel_source_select;
   input  wire        extras_active_n;
   input  wire [8:0]  direct_main;
   input  wire [3:0]  direct_swallow;
   input  wire [3:0]  direct_ref;
   input  wire        direct_pre_en_n;
   input  wire        main_divider_in;
   output reg  [8:0]  cnt_main;
   output reg  [5:0]  cnt_ref;
   output reg  [3:0]  cnt_swallow;
   output reg         prescaler_bypass;
   output reg  [7:0]  enh_effective;
   output reg         main_divider_monitor;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   wire sck_rise;
   wire sd_lvl;
   wire ew_lvl;
   wire ew_rise;
   wire sl_rise;
   wire um_rise;
   wire lm_rise;
   wire sw_rise;
   wire tr_rise;
   wire ssel_lvl;
   wire dsel_lvl;
   wire fss_lvl;
   wire fsp_lvl;
   wire enn_lvl;
   wire mdiv_lvl;

   pcp_sync u_sck (
      .clk       (clk),
      .reset     (reset),
      .async_in  (shift_clk),
      .level_out (),
      .rise_out  (sck_rise)
   );
   pcp_sync u_sd (
      .clk       (clk),
      .reset     (reset),
      .async_in  (serial_data_in),
      .level_out (sd_lvl),
      .rise_out  ()
   );
   pcp_sync u_ew (
      .clk       (clk),
      .reset     (reset),
      .async_in  (enh_strobe),
      .level_out (ew_lvl),
      .rise_out  (ew_rise)
   );
   pcp_sync u_sl (
      .clk       (clk),
      .reset     (reset),
      .async_in  (serial_load_strobe),
      .level_out (),
      .rise_out  (sl_rise)
   );
   pcp_sync u_um (
      .clk       (clk),
      .reset     (reset),
      .async_in  (upper_main_strobe),
      .level_out (),
      .rise_out  (um_rise)
   );
   pcp_sync u_lm (
      .clk       (clk),
      .reset     (reset),
      .async_in  (lower_main_strobe),
      .level_out (),
      .rise_out  (lm_rise)
   );
   pcp_sync u_sw (
      .clk       (clk),
      .reset     (reset),
      .async_in  (swallow_strobe),
      .level_out (),
      .rise_out  (sw_rise)
   );
   pcp_sync u_tr (
      .clk       (clk),
      .reset     (reset),
      .async_in  (transfer_strobe),
      .level_out (),
      .rise_out  (tr_rise)
   );
   pcp_sync u_ss (
      .clk       (clk),
      .reset     (reset),
      .async_in  (serial_select),
      .level_out (ssel_lvl),
      .rise_out  ()
   );
   pcp_sync u_ds (
      .clk       (clk),
      .reset     (reset),
      .async_in  (direct_select),
      .level_out (dsel_lvl),
      .rise_out  ()
   );
   pcp_sync u_fs (
      .clk       (clk),
      .reset     (reset),
      .async_in  (serial_source_select),
      .level_out (fss_lvl),
      .rise_out  ()
   );
   pcp_sync u_fp (
      .clk       (clk),
      .reset     (reset),
      .async_in  (parallel_source_select),
      .level_out (fsp_lvl),
      .rise_out  ()
   );
   pcp_sync u_en (
      .clk       (clk),
      .reset     (reset),
      .async_in  (extras_active_n),
      .level_out (enn_lvl),
      .rise_out  ()
   );
   pcp_sync u_md (
      .clk       (clk),
      .reset     (reset),
      .async_in  (main_divider_in),
      .level_out (mdiv_lvl),
      .rise_out  ()
   );

   // parallel data and direct pins are quasi-static, yet they still pass three
   // stages; a word counts only once stages two and three agree, so a skewed
   // bus never lands half old and half new
   reg [7:0]  pd1_r;
   reg [7:0]  pd2_r;
   reg [7:0]  pd3_r;
   reg [7:0]  pd_lvl_r;
   reg [17:0] dir1_r;
   reg [17:0] dir2_r;
   reg [17:0] dir3_r;
   reg [17:0] dir_lvl_r;
   always @(posedge clk) begin
      pd1_r  <= par_data;
      pd2_r  <= pd1_r;
      pd3_r  <= pd2_r;
      dir1_r <= {direct_pre_en_n, direct_main, direct_ref, direct_swallow};
      dir2_r <= dir1_r;
      dir3_r <= dir2_r;
      if (pd2_r == pd3_r) begin
         pd_lvl_r <= pd3_r;
      end
      if (dir2_r == dir3_r) begin
         dir_lvl_r <= dir3_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // mode decode
   wire mode_direct   = dsel_lvl;
   wire mode_serial   = !dsel_lvl && ssel_lvl;
   wire mode_parallel = !dsel_lvl && !ssel_lvl;

   ////////////////////////////////////////////////////////////////////////////////
   // programming words; no reset value, they hold until written
   reg [19:0] primary_counter_word;
   reg [19:0] secondary_word;
   reg [7:0]  enhancement_word;
   reg [19:0] pri_nxt;
   reg [7:0]  enh_nxt;

   always @* begin
      pri_nxt = primary_counter_word;
      enh_nxt = enhancement_word;
      if (mode_serial && sck_rise) begin
         // first bit shifted lands at the top, so msb first
         if (ew_lvl) begin
            enh_nxt = {enhancement_word[6:0], sd_lvl};
         end else begin
            pri_nxt = {primary_counter_word[18:0], sd_lvl};
         end
      end
      if (mode_parallel) begin
         if (ew_rise) begin
            enh_nxt = pd_lvl_r;
         end
         if (um_rise) begin
            pri_nxt[`PCP_R_HI:`PCP_R_HI-1]   = pd_lvl_r[3:2];
            pri_nxt[`PCP_M_HI:`PCP_M_HI-1]   = pd_lvl_r[1:0];
         end
         if (lm_rise) begin
            pri_nxt[`PCP_PRE_EN_BIT]         = pd_lvl_r[7];
            pri_nxt[`PCP_M_LO+6:`PCP_M_LO]   = pd_lvl_r[6:0];
         end
         if (sw_rise) begin
            pri_nxt[`PCP_R_LO+3:`PCP_R_LO]   = pd_lvl_r[7:4];
            pri_nxt[`PCP_A_HI:`PCP_A_LO]     = pd_lvl_r[3:0];
         end
      end
   end

   // only shift or strobe edges alter the words
   always @(posedge clk) begin
      primary_counter_word <= pri_nxt;
      enhancement_word     <= enh_nxt;
      if (!mode_direct && (tr_rise || (mode_serial && sl_rise))) begin
         secondary_word <= primary_counter_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // counter source selection
   reg [19:0] src_word;
   reg        use_primary;
   always @* begin
      use_primary = mode_serial ? fss_lvl : fsp_lvl;
      src_word    = use_primary ? primary_counter_word : secondary_word;
   end

   // enhancement bits apply only in serial/parallel with the enable low
   wire [7:0] enh_act = (!mode_direct && !enn_lvl) ? enhancement_word : 8'h00;

   always @(posedge clk) begin
      if (reset) begin
         cnt_main             <= `PCP_RST_MAIN;
         cnt_ref              <= `PCP_RST_REF;
         cnt_swallow          <= `PCP_DEFAULT_CNT;
         prescaler_bypass     <= 1'b0;
         enh_effective        <= `PCP_RST_ENH;
         main_divider_monitor <= 1'b0;
      end else begin
         if (mode_direct) begin
            // swallow pin 3 is the msb of the swallow count
            prescaler_bypass <= dir_lvl_r[17];
            cnt_main         <= dir_lvl_r[16:8];
            cnt_ref          <= {2'b00, dir_lvl_r[7:4]};
            cnt_swallow      <= dir_lvl_r[3:0];
         end else begin
            prescaler_bypass <= src_word[`PCP_PRE_EN_BIT];
            cnt_main         <= src_word[`PCP_M_HI:`PCP_M_LO];
            cnt_ref          <= src_word[`PCP_R_HI:`PCP_R_LO];
            cnt_swallow      <= src_word[`PCP_A_HI:`PCP_A_LO];
         end
         enh_effective <= enh_act;
         // a held-low monitor saves switching noise near the loop
         main_divider_monitor <= enh_act[`PCP_ENH_MON_OFF] ? 1'b0 : mdiv_lvl;
      end
   end
endmodule

// *** hw/pcp_sync.v ***
// three-stage input synchroniser with edge detection on agreement of stages two and three
module pcp_sync (
   clk,
   reset,
   async_in,
   level_out,
   rise_out
);
   input  wire clk;
   input  wire reset;
   input  wire async_in;
   output reg  level_out;
   output wire rise_out;

   reg s1_r;
   reg s2_r;
   reg s3_r;

   // a change counts once stages two and three agree
   always @(posedge clk) begin
      if (reset) begin
         s1_r      <= 1'b0;
         s2_r      <= 1'b0;
         s3_r      <= 1'b0;
         level_out <= 1'b0;
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_out <= s3_r;
         end
      end
   end

   assign rise_out = (s2_r == s3_r) && s3_r && !level_out;
endmodule

// *** testbench/pcp_host.sv ***
// host controller model driving the serial and parallel programming pins
module pcp_host (
   input  wire logic       clk,
   output logic            shift_clk = 1'b0,
   output logic            serial_data_in = 1'b0,
   output logic      [7:0] par_data = 8'h00,
   output wire logic       enh_strobe, serial_load_strobe, upper_main_strobe,
   output wire logic       lower_main_strobe, swallow_strobe, transfer_strobe
);
   timeunit 1ns;
   timeprecision 1ns;
   // strobe bits: enh, serial load, upper, lower, swallow, transfer
   logic [5:0] stb = 6'h00;
   assign {transfer_strobe, swallow_strobe, lower_main_strobe, upper_main_strobe,
      serial_load_strobe, enh_strobe} = stb;
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   // each pin phase lasts 4 clocks so the device synchroniser never misses it
   task automatic shift(input logic [19:0] w, input int n, input logic e);
      stb[0] = e;
      for (int i = n - 1; i >= 0; i--) begin // serial load held low meanwhile
         serial_data_in = w[i];
         idle(4);
         shift_clk = 1'b1;
         idle(4);
         shift_clk = 1'b0;
      end
      serial_data_in = 1'b0; // released pin sits at its pull-down level
      stb[0] = 1'b0;
      idle(4);
   endtask
   task automatic pulse(input int k, input logic [7:0] d);
      par_data = d;
      idle(4);
      stb[k] = 1'b1;
      idle(4);
      stb = 6'h00;
      idle(4);
      par_data = 8'h00;
      idle(4);
   endtask
endmodule

// *** testbench/pcp_port_properties.sv ***
// assertions on the counter programming port outputs
module pcp_port_props (
   input wire logic       clk, reset, direct_select, extras_active_n, direct_pre_en_n,
   input wire logic       main_divider_in, prescaler_bypass, main_divider_monitor,
   input wire logic [8:0] direct_main, cnt_main,
   input wire logic [3:0] direct_swallow, direct_ref, cnt_swallow,
   input wire logic [5:0] cnt_ref,
   input wire logic [7:0] enh_effective
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // cycles in direct mode or with extras off, saturating; 8 covers sync plus output flop
   logic [3:0] dir_q, xtr_q;
   always @(posedge clk) begin
      dir_q <= (reset || !direct_select) ? 4'h0 : dir_q + {3'h0, dir_q != 4'hf};
      xtr_q <= (reset || !extras_active_n) ? 4'h0 : xtr_q + {3'h0, xtr_q != 4'hf};
   end
   sequence s_mon_free;
      (!enh_effective[0] && $stable(main_divider_in)) [*6];
   endsequence
   a_direct_main: assert property (dir_q[3] |-> cnt_main == direct_main)
      else $error("direct main count wrong");
   a_direct_swallow: assert property (dir_q[3] |-> cnt_swallow == direct_swallow)
      else $error("direct swallow count wrong");
   a_direct_ref: assert property (dir_q[3] |-> cnt_ref == {2'h0, direct_ref})
      else $error("direct reference count wrong");
   a_direct_bypass: assert property (dir_q[3] |-> prescaler_bypass == direct_pre_en_n)
      else $error("prescaler bypass wrong");
   a_direct_no_extras: assert property (dir_q[3] |-> enh_effective == 8'h00)
      else $error("extras active in direct mode");
   a_extras_gated: assert property (xtr_q[3] |-> enh_effective == 8'h00)
      else $error("extras active while disabled");
   a_monitor_gated: assert property (enh_effective[0] [*2] |-> !main_divider_monitor)
      else $error("monitor switching while disabled");
   a_monitor_pass: assert property (s_mon_free |-> main_divider_monitor == main_divider_in)
      else $error("monitor not following divider");
   c_direct: cover property (dir_q == 4'hf);
   c_gated: cover property (enh_effective[0] && !main_divider_monitor);
   c_bypass: cover property ($rose(prescaler_bypass));
endmodule
bind pcp_port pcp_port_props chk (.*);

// *** testbench/tb.sv ***
// self-checking bench for the counter programming port
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, reset = 1'b1, serial_select = 1'b1, direct_select = 1'b0;
   logic serial_source_select = 1'b1, parallel_source_select = 1'b1, extras_active_n = 1'b0;
   logic main_divider_in = 1'b1, direct_pre_en_n = 1'b1;
   logic [8:0] direct_main = 9'h0c3;
   logic [3:0] direct_swallow = 4'h8, direct_ref = 4'h5;
   logic [19:0] w1 = {1'b1, 9'h1a5, 6'h2b, 4'h9}, w2 = {1'b0, 9'h04e, 6'h15, 4'h6};
   wire shift_clk, serial_data_in, enh_strobe, serial_load_strobe, upper_main_strobe;
   wire lower_main_strobe, swallow_strobe, transfer_strobe, prescaler_bypass;
   wire main_divider_monitor;
   wire [7:0] par_data, enh_effective;
   wire [8:0] cnt_main;
   wire [5:0] cnt_ref;
   wire [3:0] cnt_swallow;
   int err_total = 0, num_checks = 0;
   pcp_port uut (.*);
   pcp_host host (.*);
   always #50 clk = ~clk;
   task automatic chk(input logic [19:0] w, input logic [7:0] e, input logic m);
      repeat (12) @(negedge clk);
      `CHK({prescaler_bypass, cnt_main, cnt_ref, cnt_swallow}, w)
      `CHK(enh_effective, e)
      `CHK(main_divider_monitor, m)
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #500000;
      err_total++;
      stop_test;
   end
   initial begin
      repeat (10) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      host.shift(w1, 20, 1'b0);
      host.pulse(1, 8'h00);
      host.shift(w2, 20, 1'b0);
      host.shift(20'h81, 8, 1'b1);
      host.pulse(2, 8'hff);
      chk(w2, 8'h81, 1'b0);
      serial_source_select = 1'b0;
      chk(w1, 8'h81, 1'b0);
      extras_active_n = 1'b1;
      chk(w1, 8'h00, 1'b1);
      main_divider_in = 1'b0;
      chk(w1, 8'h00, 1'b0);
      main_divider_in = 1'b1;
      serial_select = 1'b0;
      extras_active_n = 1'b0;
      host.pulse(2, 8'h0e);
      host.pulse(3, 8'h35);
      host.pulse(4, 8'hc7);
      host.pulse(5, 8'h00);
      host.pulse(0, 8'h80);
      host.pulse(3, 8'hff);
      host.pulse(1, 8'h00);
      chk({1'b1, 9'h17f, 6'h3c, 4'h7}, 8'h80, 1'b1);
      parallel_source_select = 1'b0;
      chk({1'b0, 9'h135, 6'h3c, 4'h7}, 8'h80, 1'b1);
      direct_select = 1'b1;
      host.pulse(4, 8'h00);
      chk({1'b1, 9'h0c3, 2'h0, 4'h5, 4'h8}, 8'h00, 1'b1);
      direct_select = 1'b0;
      parallel_source_select = 1'b1;
      chk({1'b1, 9'h17f, 6'h3c, 4'h7}, 8'h80, 1'b1);
      stop_test;
   end
endmodule
